// File: core/brx_pkg.sv
package brx_pkg;

  // Address and instruction widths.
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned INSTR_W = 16;

  // Opcode fields of the two instructions handled here.
  localparam logic [3:0] CALL_HI_NIB = 4'h0;
  localparam logic [7:0] CALL_LO_BYTE = 8'h03;
  localparam logic [7:0] COND_HI_BYTE = 8'h89;

  // Field positions inside the instruction word.
  localparam int unsigned REG_FIELD_LSB = 8;
  localparam int unsigned DISP_W = 8;

  // Program counter operand is the instruction address plus this many bytes.
  localparam logic [31:0] PC_AHEAD_BYTES = 32'h0000_0004;
  // One instruction is this many bytes wide.
  localparam logic [31:0] INSTR_BYTES = 32'h0000_0002;

  // Cycle figures of the two instructions.
  localparam int unsigned CALL_CYCLES = 2;
  localparam int unsigned COND_TAKEN_CYCLES = 3;
  localparam int unsigned COND_NOT_TAKEN_CYCLES = 1;

  // Reset values.
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CALL_2,
    ST_SLOT_WAIT,
    ST_SLOT_RUN,
    ST_COND_2,
    ST_COND_3
  } brx_state_t;

  // True for any control-transfer opcode, used to police the delay slot.
  function automatic logic brx_is_branch(input logic [15:0] op);
    logic hit;
    hit = 1'b0;
    if (op[15:12] == 4'hA || op[15:12] == 4'hB) begin
      hit = 1'b1;
    end else if (op[15:8] == 8'h89 || op[15:8] == 8'h8B ||
                 op[15:8] == 8'h8D || op[15:8] == 8'h8F) begin
      hit = 1'b1;
    end else if (op[15:12] == 4'h0 && (op[7:0] == 8'h03 || op[7:0] == 8'h23)) begin
      hit = 1'b1;
    end else if (op[15:12] == 4'h4 && (op[7:0] == 8'h0B || op[7:0] == 8'h2B)) begin
      hit = 1'b1;
    end else if (op == 16'h000B || op == 16'h002B) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

endpackage

// File: core/brx_dec_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries one instruction word to the decoder and its decoded view back.
interface brx_dec_if;
  import brx_pkg::*;

  logic [15:0] instr; // Instruction word under decode.
  logic is_call; // Register-offset subroutine call.
  logic is_cond; // Conditional branch on a set flag.
  logic is_branch; // Any control-transfer opcode.
  logic [3:0] reg_sel; // Source general register index.
  logic [31:0] disp_ext; // Displacement, sign-extended and doubled.

  modport dec (
    input instr,
    output is_call,
    output is_cond,
    output is_branch,
    output reg_sel,
    output disp_ext
  );

  modport use_side (
    output instr,
    input is_call,
    input is_cond,
    input is_branch,
    input reg_sel,
    input disp_ext
  );
endinterface

`default_nettype wire

// File: core/brx_decode.sv
`timescale 1ns/10ps
`default_nettype none

// Pure decoder; the caller registers anything it needs to keep.
module brx_decode
  import brx_pkg::*;
(
  brx_dec_if.dec dec
);

  // Pattern match and field extraction, all combinational.
  always_comb begin
    dec.is_call = (dec.instr[15:12] == CALL_HI_NIB) && (dec.instr[7:0] == CALL_LO_BYTE); // RULE_01
    dec.is_cond = (dec.instr[15:8] == COND_HI_BYTE); // RULE_10
    dec.is_branch = brx_is_branch(dec.instr);
    dec.reg_sel = dec.instr[REG_FIELD_LSB +: 4];
    // Sign-extend the byte and shift left one, giving -256 to +254.
    dec.disp_ext = {{23{dec.instr[DISP_W-1]}}, dec.instr[DISP_W-1:0], 1'b0}; // RULE_12
  end

endmodule

`default_nettype wire

// File: core/brx_target_add.sv
`timescale 1ns/10ps
`default_nettype none

// Shared target adder: instruction address plus four, plus an offset.
module brx_target_add
  import brx_pkg::*;
(
  input wire logic [31:0] instr_addr,
  input wire logic [31:0] offset,
  output logic [31:0] pc_operand,
  output logic [31:0] target
);

  // The program counter seen by a branch runs two instructions ahead.
  always_comb begin
    pc_operand = instr_addr + PC_AHEAD_BYTES; // RULE_04
    target = pc_operand + offset; // RULE_03
  end

endmodule

`default_nettype wire

// File: core/brx_unit.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// RULE_01: Decode register call; two cycles, flag untouched.
// RULE_02: Call saves program counter into return register.
// RULE_03: Call target adds full 32-bit source register.
// RULE_04: Program counter operand is instruction address plus four.
// RULE_05: Call redirects only after slot instruction completes.
// RULE_06: No interrupt or address error before slot.
// RULE_07: Branch in delay slot raises illegal slot.
// RULE_08: Target operands captured before slot executes.
// RULE_09: Return resumes right after the delay slot.
// RULE_10: Decode flag branch; three cycles taken, one not.
// RULE_11: Flag set branches without slot, else sequential.
// RULE_12: Displacement sign-extended, doubled, added to counter.
// RULE_13: Not taken advances two bytes, no flush.
module brx_unit
  import brx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [15:0] instr,
  input wire logic [31:0] instr_addr,
  input wire logic flag_t,
  output logic [3:0] reg_sel,
  input wire logic [31:0] reg_data,
  output logic slot_issue,
  input wire logic slot_retire,
  output logic ret_write,
  output logic [31:0] ret_data,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic flush,
  output logic seq_valid,
  output logic [31:0] seq_pc,
  output logic done,
  output logic block_irq,
  output logic block_addr_err,
  output logic illegal_slot,
  output logic [31:0] illegal_slot_addr
);
  import brx_pkg::*;

  brx_dec_if dec_bus (); // Decoded view of the incoming word.
  logic [31:0] pc_operand; // Instruction address plus four.
  logic [31:0] target_sum; // Shared adder result.
  logic [31:0] add_offset; // Offset fed to the shared adder.
  logic accept; // An instruction is taken this cycle.

  brx_state_t state_reg; // Sequencer state.
  brx_state_t state_next;
  logic [31:0] target_reg; // Captured branch destination.
  logic [31:0] target_next;
  logic ret_write_reg; // Return register write strobe.
  logic ret_write_next;
  logic [31:0] ret_data_reg; // Value for the return register.
  logic [31:0] ret_data_next;
  logic redirect_reg; // Redirect strobe.
  logic redirect_next;
  logic flush_reg; // Pipeline flush strobe.
  logic flush_next;
  logic seq_reg; // Sequential advance strobe.
  logic seq_next;
  logic [31:0] seq_pc_reg; // Next sequential address.
  logic [31:0] seq_pc_next;
  logic done_reg; // Instruction completion strobe.
  logic done_next;
  logic block_reg; // Interrupt and address-error hold-off.
  logic block_next;
  logic illegal_reg; // Illegal slot strobe.
  logic illegal_next;
  logic [31:0] illegal_addr_reg; // Address of the offending slot word.
  logic [31:0] illegal_addr_next;

  // The decoder looks at the word on the issue port.
  assign dec_bus.instr = instr;

  brx_decode u_decode (
    .dec(dec_bus)
  );

  // One adder serves both instructions; only one is ever being accepted.
  always_comb begin
    if (dec_bus.is_call) begin
      add_offset = reg_data; // RULE_03
    end else begin
      add_offset = dec_bus.disp_ext; // RULE_12
    end
  end

  brx_target_add u_add (
    .instr_addr(instr_addr),
    .offset(add_offset),
    .pc_operand(pc_operand),
    .target(target_sum)
  );

  // The register file is read in the same cycle as the call is accepted.
  assign reg_sel = dec_bus.reg_sel;

  // Ready while idle with no redirect leaving, or while waiting for the slot word; this keeps a new
  // instruction from slipping in ahead of a control transfer.
  always_comb begin
    instr_ready = 1'b0;
    if (state_reg == ST_IDLE) begin
      instr_ready = !redirect_reg;
    end else if (state_reg == ST_SLOT_WAIT) begin
      instr_ready = 1'b1;
    end
  end

  assign accept = instr_valid && instr_ready && (state_reg == ST_IDLE);

  // A legal slot word is handed to the core for execution.
  assign slot_issue = instr_valid && (state_reg == ST_SLOT_WAIT) && !dec_bus.is_branch;

  // Next-state logic for the sequencer and every strobe it drives.
  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    ret_write_next = 1'b0;
    ret_data_next = ret_data_reg;
    redirect_next = 1'b0;
    flush_next = 1'b0;
    seq_next = 1'b0;
    seq_pc_next = seq_pc_reg;
    done_next = 1'b0;
    block_next = block_reg;
    illegal_next = 1'b0;
    illegal_addr_next = illegal_addr_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept && dec_bus.is_call) begin
          // Operands are frozen now, so the slot cannot move the target.
          target_next = target_sum; // RULE_08
          // The saved address is the word after the delay slot.
          ret_data_next = pc_operand; // RULE_02 RULE_09
          ret_write_next = 1'b1; // RULE_02
          // Hold off interrupts and address errors until the slot is done.
          block_next = 1'b1; // RULE_06
          state_next = ST_CALL_2; // RULE_01
        end else if (accept && dec_bus.is_cond) begin
          if (flag_t) begin
            target_next = target_sum; // RULE_11
            state_next = ST_COND_2; // RULE_10
          end else begin
            // Fall through: one cycle, plain advance, nothing flushed.
            seq_next = 1'b1; // RULE_13
            seq_pc_next = instr_addr + INSTR_BYTES; // RULE_11 RULE_13
            done_next = 1'b1; // RULE_10
          end
        end
      end
      ST_CALL_2: begin
        // Second cycle of the call; the flag is never written here.
        done_next = 1'b1; // RULE_01
        state_next = ST_SLOT_WAIT; // RULE_05
      end
      ST_SLOT_WAIT: begin
        if (instr_valid) begin
          if (dec_bus.is_branch) begin
            // A branch in the slot is refused and the call abandoned.
            illegal_next = 1'b1; // RULE_07
            illegal_addr_next = instr_addr; // RULE_07
            block_next = 1'b0;
            state_next = ST_IDLE;
          end else begin
            state_next = ST_SLOT_RUN; // RULE_05
          end
        end
      end
      ST_SLOT_RUN: begin
        if (slot_retire) begin
          // Control moves only once the slot word has fully executed.
          redirect_next = 1'b1; // RULE_05
          flush_next = 1'b1;
          block_next = 1'b0; // RULE_06
          state_next = ST_IDLE;
        end
      end
      ST_COND_2: begin
        // Taken branch has no slot: redirect and flush straight away.
        redirect_next = 1'b1; // RULE_11
        flush_next = 1'b1; // RULE_11
        state_next = ST_COND_3; // RULE_10
      end
      ST_COND_3: begin
        done_next = 1'b1; // RULE_10
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
        block_next = 1'b0;
      end
    endcase
  end

  // Registers only; all decisions are made above.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      target_reg <= ADDR_RESET;
      ret_write_reg <= 1'b0;
      ret_data_reg <= ADDR_RESET;
      redirect_reg <= 1'b0;
      flush_reg <= 1'b0;
      seq_reg <= 1'b0;
      seq_pc_reg <= ADDR_RESET;
      done_reg <= 1'b0;
      block_reg <= 1'b0;
      illegal_reg <= 1'b0;
      illegal_addr_reg <= ADDR_RESET;
    end else begin
      state_reg <= state_next;
      target_reg <= target_next;
      ret_write_reg <= ret_write_next;
      ret_data_reg <= ret_data_next;
      redirect_reg <= redirect_next;
      flush_reg <= flush_next;
      seq_reg <= seq_next;
      seq_pc_reg <= seq_pc_next;
      done_reg <= done_next;
      block_reg <= block_next;
      illegal_reg <= illegal_next;
      illegal_addr_reg <= illegal_addr_next;
    end
  end

  // Every output assigned here comes straight from a flip-flop.
  assign ret_write = ret_write_reg;
  assign ret_data = ret_data_reg;
  assign redirect_valid = redirect_reg;
  assign redirect_pc = target_reg;
  assign flush = flush_reg;
  assign seq_valid = seq_reg;
  assign seq_pc = seq_pc_reg;
  assign done = done_reg;
  assign block_irq = block_reg; // RULE_06
  assign block_addr_err = block_reg; // RULE_06
  assign illegal_slot = illegal_reg;
  assign illegal_slot_addr = illegal_addr_reg;

endmodule

`default_nettype wire

// File: tb/brx_unit_sva.sv
`timescale 1ns/10ps
`default_nettype none

// Watches the unit's ports; a call or branch seen at an idle accept must answer on time.
module brx_unit_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [15:0] instr,
  input wire logic [31:0] instr_addr,
  input wire logic flag_t,
  input wire logic slot_issue,
  input wire logic slot_retire,
  input wire logic ret_write,
  input wire logic [31:0] ret_data,
  input wire logic redirect_valid,
  input wire logic [31:0] redirect_pc,
  input wire logic flush,
  input wire logic seq_valid,
  input wire logic [31:0] seq_pc,
  input wire logic done,
  input wire logic block_irq,
  input wire logic block_addr_err,
  input wire logic illegal_slot,
  input wire logic [31:0] illegal_slot_addr
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Blocking is low when idle, so this separates an idle accept from a slot accept.
  wire logic idle_acc = instr_valid && instr_ready && !block_irq;
  wire logic is_call = instr[15:12] == 4'h0 && instr[7:0] == 8'h03;
  wire logic is_cond = instr[15:8] == 8'h89;

  a_call_save_ret: assert property (idle_acc && is_call |=> ret_write &&
    ret_data == $past(instr_addr) + 32'h4) else $error("call return value wrong");
  a_call_two_cyc: assert property (idle_acc && is_call |-> ##2 done && block_irq)
    else $error("call did not finish in two cycles");
  a_ret_held: assert property (!ret_write |-> $stable(ret_data))
    else $error("return value moved without a call");
  a_redirect_retire: assert property (block_irq && !instr_ready && slot_retire |=>
    redirect_valid && flush && !block_irq) else $error("no redirect after slot");
  a_block_pair: assert property (block_irq == block_addr_err)
    else $error("interrupt and address error blocks differ");
  a_slot_illegal: assert property (block_irq && instr_valid && instr_ready && !slot_issue
    |=> illegal_slot && !redirect_valid && illegal_slot_addr == $past(instr_addr))
    else $error("branch in slot not flagged");
  a_cond_taken_pc: assert property (idle_acc && is_cond && flag_t |-> ##2 redirect_valid &&
    flush && redirect_pc == $past(instr_addr, 2) + 32'h4 +
    {{23{$past(instr[7], 2)}}, $past(instr[7:0], 2), 1'b0}) else $error("taken target wrong");
  a_cond_taken_cyc: assert property (idle_acc && is_cond && flag_t |=> !done [*2] ##1 done)
    else $error("taken branch not three cycles");
  a_cond_not_taken: assert property (idle_acc && is_cond && !flag_t |=> seq_valid && done &&
    !flush && seq_pc == $past(instr_addr) + 32'h2) else $error("not-taken step wrong");
  a_flush_redir: assert property (flush |-> redirect_valid)
    else $error("flush without redirect");
endmodule

bind brx_unit brx_unit_sva chk_i (
  .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
  .instr(instr), .instr_addr(instr_addr), .flag_t(flag_t), .slot_issue(slot_issue),
  .slot_retire(slot_retire), .ret_write(ret_write), .ret_data(ret_data),
  .redirect_valid(redirect_valid), .redirect_pc(redirect_pc), .flush(flush),
  .seq_valid(seq_valid), .seq_pc(seq_pc), .done(done), .block_irq(block_irq),
  .block_addr_err(block_addr_err), .illegal_slot(illegal_slot),
  .illegal_slot_addr(illegal_slot_addr)
);

`default_nettype wire

// File: tb/brx_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module brx_unit_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic flag_t = 1'b0;
  logic slot_retire = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [31:0] instr_addr = 32'h0000_0000;
  logic [31:0] rf [16]; // Register file seen by the unit's read port.
  logic instr_ready, slot_issue, ret_write, redirect_valid, flush, seq_valid, done;
  logic block_irq, block_addr_err, illegal_slot;
  logic [3:0] reg_sel;
  logic [31:0] reg_data, ret_data, redirect_pc, seq_pc, illegal_slot_addr;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  assign reg_data = rf[reg_sel];

  brx_unit dut (
    .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr(instr), .instr_addr(instr_addr), .flag_t(flag_t), .reg_sel(reg_sel),
    .reg_data(reg_data), .slot_issue(slot_issue), .slot_retire(slot_retire),
    .ret_write(ret_write), .ret_data(ret_data), .redirect_valid(redirect_valid),
    .redirect_pc(redirect_pc), .flush(flush), .seq_valid(seq_valid), .seq_pc(seq_pc),
    .done(done), .block_irq(block_irq), .block_addr_err(block_addr_err),
    .illegal_slot(illegal_slot), .illegal_slot_addr(illegal_slot_addr)
  );

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // A hang ends the run as a failure; the tests need well under this.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Presents one word from a falling edge and returns at the falling edge after acceptance.
  task automatic issue(input logic [15:0] op, input logic [31:0] a, input logic f);
    instr = op;
    instr_addr = a;
    flag_t = f;
    instr_valid = 1'b1;
    #1 chk("instr_ready", 1, instr_ready);
    @(posedge clk_sys);
    @(negedge clk_sys);
    instr_valid = 1'b0;
  endtask

  // Call with a slow slot retire; the slot overwrites the offset register.
  task automatic test_call();
    rf[5] = 32'h8000_1000;
    issue(16'h0503, 32'h0000_2000, 1'b1);
    chk("reg_sel", 32'h0000_0005, {28'h0000000, reg_sel});
    rf[5] = 32'h0000_0010;
    chk("ret_write", 1, ret_write);
    chk("ret_data", 32'h0000_2004, ret_data);
    chk("block_irq", 1, block_irq);
    @(negedge clk_sys);
    chk("done", 1, done);
    instr = 16'h6033;
    instr_addr = 32'h0000_2002;
    instr_valid = 1'b1;
    #1 chk("slot_issue", 1, slot_issue);
    @(negedge clk_sys);
    instr_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("redirect_valid", 0, redirect_valid);
    chk("block_addr_err", 1, block_addr_err);
    slot_retire = 1'b1;
    @(negedge clk_sys);
    slot_retire = 1'b0;
    chk("redirect_valid", 1, redirect_valid);
    chk("redirect_pc", 32'h8000_3004, redirect_pc);
    chk("ret_data", 32'h0000_2002 + 32'h2, ret_data);
    @(negedge clk_sys);
    $display("test call finished");
  endtask

  // A branch from four of the five families placed in the slot must be refused as illegal.
  task automatic test_illegal();
    logic [15:0] ops [4];
    ops = '{16'hA123, 16'h8B10, 16'h0423, 16'h000B};
    for (int i = 0; i < 4; i++) begin
      issue(16'h0203, 32'h0000_4000, 1'b0);
      @(negedge clk_sys);
      instr = ops[i];
      instr_addr = 32'h0000_4002;
      instr_valid = 1'b1;
      #1 chk("slot_issue", 0, slot_issue);
      @(negedge clk_sys);
      instr_valid = 1'b0;
      chk("illegal_slot", 1, illegal_slot);
      chk("illegal_slot_addr", 32'h0000_4002, illegal_slot_addr);
      chk("redirect_valid", 0, redirect_valid);
    end
    $display("test illegal slot finished");
  endtask

  // Taken branch at both ends of the displacement reach.
  task automatic test_cond_taken();
    logic [7:0] d;
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 8'h80 : 8'h7F;
      issue({8'h89, d}, 32'h0000_8000, 1'b1);
      chk("redirect_valid", 0, redirect_valid);
      @(negedge clk_sys);
      chk("flush", 1, flush);
      chk("redirect_pc", 32'h0000_8004 + {{23{d[7]}}, d, 1'b0}, redirect_pc);
      @(negedge clk_sys);
      chk("done", 1, done);
      @(negedge clk_sys);
    end
    $display("test taken branch finished");
  endtask

  // Not-taken branches back to back, then a near-call word that must be ignored.
  task automatic test_cond_not();
    issue(16'h8905, 32'h0000_9000, 1'b0);
    chk("seq_pc", 32'h0000_9002, seq_pc);
    chk("flush", 0, flush);
    issue(16'h89FF, 32'h0000_9002, 1'b0);
    chk("seq_valid", 1, seq_valid);
    chk("done", 1, done);
    issue(16'h0513, 32'h0000_9004, 1'b0);
    chk("ret_write", 0, ret_write);
    $display("test not-taken branch finished");
  endtask

  initial begin
    for (int i = 0; i < 16; i++) begin
      rf[i] = 32'h0000_0100 * i;
    end
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    test_call();
    test_illegal();
    test_cond_taken();
    test_cond_not();
    final_report();
  end
endmodule

`default_nettype wire
